// ===== dsc_pkg.sv
package dsc_pkg;
    // ************************************************************
    // serial frame layout: 4 address bits then 18 data bits, msb first
    // ************************************************************
    localparam int DATA_W = 18;
    localparam int ADDR_W = 4;
    localparam int FRAME_W = DATA_W + ADDR_W;
    localparam logic [4:0] FRAME_BITS = 5'h16;

    // ************************************************************
    // register addresses
    // ************************************************************
    localparam logic [3:0] ADDR_MAIN_CFG = 4'h0;
    localparam logic [3:0] ADDR_POWER_CTRL = 4'h2;
    localparam logic [3:0] ADDR_SYNTH_ONE_DIV = 4'h3;
    localparam logic [3:0] ADDR_SYNTH_TWO_DIV = 4'h4;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int AUX_SEL_HI = 13;
    localparam int AUX_SEL_LO = 12;
    localparam int REF_DIV_BIT = 6;
    localparam int SYNTH_EN_BIT = 0;
    localparam int TWO_DIV_W = 17;

    // ************************************************************
    // field codes
    // ************************************************************
    localparam logic [1:0] AUX_FORCE_LOW = 2'h1;
    localparam logic [1:0] AUX_LOCK_MARGIN = 2'h3;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [1:0] AUX_SEL_RST = 2'h1;
    localparam logic REF_DIV_RST = 1'b0;
    localparam logic SYNTH_EN_RST = 1'b0;
    localparam logic [17:0] ONE_DIV_RST = 18'h00000;
    localparam logic [16:0] TWO_DIV_RST = 17'h00000;

    // ************************************************************
    // reference divide ratios and timeline in half update periods
    // ************************************************************
    localparam logic [7:0] REF_DIV_SHORT = 8'h41; // 65
    localparam logic [7:0] REF_DIV_LONG = 8'h82;  // 130
    localparam logic [5:0] TUNE_HALVES = 6'h0d;   // 6.5 update periods
    localparam logic [5:0] SETTLE_HALVES = 6'h38; // 28 update periods
    localparam logic [5:0] FINE_HALVES = 6'h2a;   // 21 update periods of fine settling

    // ************************************************************
    // nominal timing at a 13 MHz reference
    // ************************************************************
    localparam int REF_FREQ_KHZ = 13000;
    localparam int UPDATE_PERIOD_NS = 5000;
    localparam int SETTLE_TIME_US = 140;
    localparam int SETTLE_TIME_NS = SETTLE_TIME_US * 1000;
    localparam int SETTLE_PERIODS = SETTLE_TIME_NS / UPDATE_PERIOD_NS;

    // ************************************************************
    // loop phase
    // ************************************************************
    typedef enum logic [1:0] {
        DSC_OFF = 2'b00,
        DSC_TUNE = 2'b01,
        DSC_SETTLE = 2'b10,
        DSC_LOCKED = 2'b11
    } dsc_phase_e;
endpackage

// ===== dsc_sync.sv
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// two flop synchroniser for a bundle of pin levels
// ************************************************************
module dsc_sync #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    // first stage feeds only the second stage
    always_comb begin
        meta_nxt = d;
        q_nxt = meta_r;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            q_r <= q_nxt;
        end
    end

    assign q = q_r;
endmodule // dsc_sync
`default_nettype wire

// ===== dsc_bank.sv
`timescale 1ns/1ns
`default_nettype none
module dsc_bank
    import dsc_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic serial_enable_n,
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic power_down_pin,
    input wire logic reference_input_pin,
    input wire logic near_limit_pin,
    output logic ref_amp_on,
    output logic rf_circuit_on,
    output logic rf_output_pin_sel_two,
    output logic aux_output_pin,
    output logic lock_margin_flag_n,
    output logic tuning,
    output logic settled,
    output logic [17:0] band_one_divide_value,
    output logic [16:0] band_two_divide_value
);
    // ************************************************************
    // pin synchronisation
    // ************************************************************
    logic [5:0] pins_s;
    logic sen_s, sclk_s, sdat_s, power_down_pin_s, ref_s, near_s;

    dsc_sync #(.W(6)) u_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .d({serial_enable_n, serial_clk, serial_data, power_down_pin,
            reference_input_pin, near_limit_pin}),
        .q(pins_s)
    );
    assign {sen_s, sclk_s, sdat_s, power_down_pin_s, ref_s, near_s} = pins_s;

    // ************************************************************
    // serial port and write-only registers
    // ************************************************************
    logic sen_d_r, sen_d_nxt, sclk_d_r, sclk_d_nxt;
    logic [FRAME_W-1:0] shift_r, shift_nxt;
    logic [4:0] nbits_r, nbits_nxt;
    logic [1:0] aux_sel_r, aux_sel_nxt;
    logic ref_div_r, ref_div_nxt;
    logic synth_en_r, synth_en_nxt;
    logic [17:0] one_div_r, one_div_nxt;
    logic [16:0] two_div_r, two_div_nxt;
    logic sel_two_r, sel_two_nxt;
    logic freq_write;
    logic [3:0] waddr;
    logic [DATA_W-1:0] wdata;
    logic frame_end;

    assign waddr = shift_r[FRAME_W-1:DATA_W];
    assign wdata = shift_r[DATA_W-1:0];
    // a frame counts only when exactly the full number of bits arrived
    assign frame_end = sen_s && !sen_d_r && (nbits_r == FRAME_BITS);

    // bits shift in on serial clock rise while enable is low, take effect at enable rise
    always_comb begin
        sen_d_nxt = sen_s;
        sclk_d_nxt = sclk_s;
        shift_nxt = shift_r;
        nbits_nxt = nbits_r;
        aux_sel_nxt = aux_sel_r;
        ref_div_nxt = ref_div_r;
        synth_en_nxt = synth_en_r;
        one_div_nxt = one_div_r;
        two_div_nxt = two_div_r;
        sel_two_nxt = sel_two_r;
        freq_write = 1'b0;
        if (sen_s) begin
            nbits_nxt = 5'h00;
        end else if (sclk_s && !sclk_d_r) begin
            shift_nxt = {shift_r[FRAME_W-2:0], sdat_s};
            if (nbits_r != 5'h1f) begin
                nbits_nxt = nbits_r + 5'h01;
            end
        end
        if (frame_end) begin
            // reserved addresses are ignored; host is not to use them
            case (waddr)
                ADDR_MAIN_CFG: begin
                    aux_sel_nxt = wdata[AUX_SEL_HI:AUX_SEL_LO];
                    ref_div_nxt = wdata[REF_DIV_BIT];
                end
                ADDR_POWER_CTRL: begin
                    synth_en_nxt = wdata[SYNTH_EN_BIT];
                end
                ADDR_SYNTH_ONE_DIV: begin
                    one_div_nxt = wdata;
                    sel_two_nxt = 1'b0;
                    freq_write = 1'b1;
                end
                ADDR_SYNTH_TWO_DIV: begin
                    two_div_nxt = wdata[TWO_DIV_W-1:0];
                    sel_two_nxt = 1'b1;
                    freq_write = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sen_d_r <= 1'b1;
            sclk_d_r <= 1'b0;
            shift_r <= '0;
            nbits_r <= 5'h00;
            aux_sel_r <= AUX_SEL_RST;
            ref_div_r <= REF_DIV_RST;
            synth_en_r <= SYNTH_EN_RST;
            one_div_r <= ONE_DIV_RST;
            two_div_r <= TWO_DIV_RST;
            sel_two_r <= 1'b0;
        end else begin
            sen_d_r <= sen_d_nxt;
            sclk_d_r <= sclk_d_nxt;
            shift_r <= shift_nxt;
            nbits_r <= nbits_nxt;
            aux_sel_r <= aux_sel_nxt;
            ref_div_r <= ref_div_nxt;
            synth_en_r <= synth_en_nxt;
            one_div_r <= one_div_nxt;
            two_div_r <= two_div_nxt;
            sel_two_r <= sel_two_nxt;
        end
    end

    // ************************************************************
    // power, reference divider and tuning timeline
    // ************************************************************
    logic power_on;
    logic ref_d_r, ref_d_nxt;
    logic [7:0] half_cnt_r, half_cnt_nxt;
    logic [5:0] halves_r, halves_nxt;
    logic on_d_r, on_d_nxt;
    dsc_phase_e phase_r, phase_nxt;
    logic half_tick;
    logic [7:0] half_len;

    assign power_on = power_down_pin_s && synth_en_r;
    // counting both reference edges lets an odd ratio give exact half periods
    assign half_len = ref_div_r ? REF_DIV_LONG : REF_DIV_SHORT;
    // at or past the end, so a ratio change mid count cannot run the counter through its wrap
    assign half_tick = (ref_s != ref_d_r) && (half_cnt_r >= half_len - 8'h01);

    // timeline counts half update periods, so it scales with the period
    always_comb begin
        ref_d_nxt = ref_s;
        on_d_nxt = power_on;
        half_cnt_nxt = half_cnt_r;
        halves_nxt = halves_r;
        phase_nxt = phase_r;
        if (ref_s != ref_d_r) begin
            half_cnt_nxt = half_tick ? 8'h00 : half_cnt_r + 8'h01;
        end
        if (half_tick && phase_r != DSC_LOCKED) begin
            halves_nxt = halves_r + 6'h01;
        end
        unique case (phase_r)
            DSC_OFF: begin
                halves_nxt = 6'h00;
            end
            DSC_TUNE: begin
                if (halves_r == TUNE_HALVES) begin
                    phase_nxt = DSC_SETTLE;
                end
            end
            DSC_SETTLE: begin
                if (halves_r == SETTLE_HALVES) begin
                    phase_nxt = DSC_LOCKED;
                end
            end
            DSC_LOCKED: begin
            end
        endcase
        // powerup or a new frequency restarts the whole timeline
        if (!power_on) begin
            phase_nxt = DSC_OFF;
            halves_nxt = 6'h00;
        end else if ((power_on && !on_d_r) || freq_write) begin
            phase_nxt = DSC_TUNE;
            halves_nxt = 6'h00;
            half_cnt_nxt = 8'h00;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ref_d_r <= 1'b0;
            on_d_r <= 1'b0;
            half_cnt_r <= 8'h00;
            halves_r <= 6'h00;
            phase_r <= DSC_OFF;
        end else begin
            ref_d_r <= ref_d_nxt;
            on_d_r <= on_d_nxt;
            half_cnt_r <= half_cnt_nxt;
            halves_r <= halves_nxt;
            phase_r <= phase_nxt;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    logic flag_n;
    // flag is high when off or tuning, else follows the compensation limit
    assign flag_n = (phase_r == DSC_OFF) || (phase_r == DSC_TUNE) || near_s;
    assign ref_amp_on = power_on;
    assign rf_circuit_on = power_on;
    assign rf_output_pin_sel_two = sel_two_r;
    // reserved codes also drive low so the pin is never left floating
    assign aux_output_pin = (aux_sel_r == AUX_LOCK_MARGIN) ? flag_n : 1'b0;
    assign lock_margin_flag_n = flag_n;
    assign tuning = (phase_r == DSC_TUNE);
    assign settled = (phase_r == DSC_LOCKED);
    assign band_one_divide_value = one_div_r;
    assign band_two_divide_value = two_div_r;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_pin_forces_off: assert property (!power_down_pin_s |-> !ref_amp_on && !rf_circuit_on)
        else $error("power down pin did not force power off");
    a_enable_bit_power: assert property (power_down_pin_s |-> (rf_circuit_on == synth_en_r))
        else $error("enable bit does not steer power");
    a_sel_follows_write: assert property (frame_end && waddr == ADDR_SYNTH_TWO_DIV
        |=> rf_output_pin_sel_two)
        else $error("writing synth two divide did not select it");
    a_tune_length: assert property (phase_r == DSC_TUNE && halves_r == TUNE_HALVES
        && power_on && !freq_write |=> phase_r == DSC_SETTLE)
        else $error("tuning did not end after 13 half periods");
    a_settle_total: assert property (phase_r == DSC_SETTLE |-> halves_r <= SETTLE_HALVES)
        else $error("settling overran 28 update periods");
    a_half_scale: assert property (phase_r != DSC_OFF && power_on && !freq_write
        && !half_tick |=> halves_r == $past(halves_r))
        else $error("timeline moved without a half period tick");
    a_aux_low: assert property (aux_sel_r == AUX_FORCE_LOW |-> !aux_output_pin)
        else $error("aux output not forced low");
    a_aux_flag: assert property (aux_sel_r == AUX_LOCK_MARGIN
        |-> aux_output_pin == lock_margin_flag_n)
        else $error("aux output not carrying the flag");
    a_ratio_write: assert property (frame_end && waddr == ADDR_MAIN_CFG
        |=> ref_div_r == $past(wdata[REF_DIV_BIT]))
        else $error("divider select not stored");
    a_one_div: assert property (frame_end && waddr == ADDR_SYNTH_ONE_DIV
        |=> band_one_divide_value == $past(wdata) && !rf_output_pin_sel_two)
        else $error("synth one divide not stored");
    a_two_div: assert property (frame_end && waddr == ADDR_SYNTH_TWO_DIV
        |=> band_two_divide_value == $past(wdata[TWO_DIV_W-1:0]))
        else $error("synth two divide not stored");
    a_en_bit: assert property (frame_end && waddr == ADDR_POWER_CTRL
        |=> synth_en_r == $past(wdata[SYNTH_EN_BIT]))
        else $error("enable bit not stored");
    a_flag_tuning: assert property (tuning |-> lock_margin_flag_n)
        else $error("flag low while tuning");
    a_flag_locked: assert property (settled && !near_s |-> !lock_margin_flag_n)
        else $error("flag high after tuning with margin");
endmodule // dsc_bank
`default_nettype wire

// ===== dsc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// host controller programming the serial register port
// ************************************************************
module dsc_host_model
    import dsc_pkg::*;
(
    input wire logic core_clk,
    output logic serial_enable_n,
    output logic serial_clk,
    output logic serial_data
);
    // each level is held longer than the three cycles the pin sampling needs
    localparam int HOLD = 4;

    // idle port: enable high, serial clock stands still
    initial begin
        serial_enable_n = 1'b1;
        serial_clk = 1'b0;
        serial_data = 1'b0;
    end

    task automatic hold_cycles(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // one whole frame, address first, msb first; only listed addresses are ever sent
    task automatic write_reg(input logic [3:0] addr, input logic [17:0] data);
        logic [21:0] frame;
        frame = {addr, data};
        @(negedge core_clk);
        serial_enable_n = 1'b0;
        for (int i = FRAME_W - 1; i >= 0; i--) begin
            serial_data = frame[i];
            hold_cycles(HOLD);
            serial_clk = 1'b1;
            hold_cycles(HOLD);
            serial_clk = 1'b0;
        end
        hold_cycles(HOLD);
        serial_enable_n = 1'b1;
        serial_data = ~serial_data; // a deselected data line does not keep its last bit
        hold_cycles(HOLD);
    endtask

    // reserved bits zero except bit 1, which is one
    task automatic write_main(input logic [1:0] aux, input logic ref_divide_select);
        write_reg(ADDR_MAIN_CFG, {4'h0, aux, 5'h00, ref_divide_select, 4'h0, 1'b1, 1'b0});
    endtask

    task automatic write_power(input logic en);
        write_reg(ADDR_POWER_CTRL, {17'h00000, en});
    endtask

    task automatic write_one(input logic [17:0] n);
        write_reg(ADDR_SYNTH_ONE_DIV, n);
    endtask

    // bit 17 of the second divide register is always sent as zero
    task automatic write_two(input logic [16:0] n);
        write_reg(ADDR_SYNTH_TWO_DIV, {1'b0, n});
    endtask
endmodule // dsc_host_model
`default_nettype wire

// ===== dsc_bank_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module dsc_bank_tb_top;
    logic core_clk, nrst, serial_enable_n, serial_clk, serial_data;
    logic power_down_pin, reference_input_pin, near_limit_pin;
    logic ref_amp_on, rf_circuit_on, rf_output_pin_sel_two, aux_output_pin;
    logic lock_margin_flag_n, tuning, settled, tuning_d, settled_d;
    logic [17:0] band_one_divide_value;
    logic [16:0] band_two_divide_value;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int ref_edges = 0;
    int tune_start = 0;
    int tune_end = 0;
    int settle_at = 0;

    dsc_bank dut (.core_clk(core_clk), .nrst(nrst), .serial_enable_n(serial_enable_n),
        .serial_clk(serial_clk), .serial_data(serial_data), .power_down_pin(power_down_pin),
        .reference_input_pin(reference_input_pin), .near_limit_pin(near_limit_pin),
        .ref_amp_on(ref_amp_on), .rf_circuit_on(rf_circuit_on),
        .rf_output_pin_sel_two(rf_output_pin_sel_two), .aux_output_pin(aux_output_pin),
        .lock_margin_flag_n(lock_margin_flag_n), .tuning(tuning), .settled(settled),
        .band_one_divide_value(band_one_divide_value),
        .band_two_divide_value(band_two_divide_value));
    dsc_host_model host (.core_clk(core_clk), .serial_enable_n(serial_enable_n),
        .serial_clk(serial_clk), .serial_data(serial_data));

    // ************************************************************
    // clock, reference and timeline capture
    // ************************************************************
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // reference toggles every 4 cycles so the synchroniser sees each level; hang guard
    always @(negedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles % 4 == 0) begin
            reference_input_pin <= ~reference_input_pin;
            ref_edges <= ref_edges + 1;
        end
        if (cycles == 70000) begin
            bad_count++;
            complete_run();
        end
    end

    // record the reference edge count at tuning start, tuning end and lock
    always @(posedge core_clk) begin
        tuning_d <= tuning;
        settled_d <= settled;
        if (tuning === 1'b1 && tuning_d === 1'b0) tune_start <= ref_edges;
        if (tuning === 1'b0 && tuning_d === 1'b1) tune_end <= ref_edges;
        if (settled === 1'b1 && settled_d === 1'b0) settle_at <= ref_edges;
    end

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // edge counts allow a few edges for pin synchronisation
    task automatic near(input string what, input int exp, input int got);
        comparisons++;
        if (got < exp - 3 || got > exp + 3) begin
            bad_count++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic timeline(input int r);
        int n;
        n = 0;
        while (tuning !== 1'b1 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        chk("flag while tuning", 32'h1, lock_margin_flag_n);
        n = 0;
        while (settled !== 1'b1 && n < 60000) begin
            @(negedge core_clk);
            n++;
        end
        @(negedge core_clk);
        near("tune edges", int'(dsc_pkg::TUNE_HALVES) * r, tune_end - tune_start);
        near("settle edges", int'(dsc_pkg::SETTLE_HALVES) * r, settle_at - tune_start);
    endtask

    task automatic complete_run();
        $display("counts: comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        chk("enable", 32'h0, ref_amp_on);
        chk("select two", 32'h0, rf_output_pin_sel_two);
        chk("aux", 32'h0, aux_output_pin);
        chk("flag", 32'h1, lock_margin_flag_n);
        chk("divides", 32'h0, {band_one_divide_value, band_two_divide_value[13:0]});
        $display("test reset done");
    endtask

    // power up at divide 65, flag routed to aux, then loop near its limit
    task automatic t_tune_short();
        host.write_main(2'h3, 1'b0);
        chk("aux flag while off", 32'h1, aux_output_pin);
        host.write_power(1'b1);
        timeline(65);
        chk("on", 32'h1, ref_amp_on);
        chk("flag after tune", 32'h0, lock_margin_flag_n);
        chk("aux after tune", 32'h0, aux_output_pin);
        near_limit_pin = 1'b1;
        repeat (6) @(negedge core_clk);
        chk("aux near limit", 32'h1, aux_output_pin);
        near_limit_pin = 1'b0;
        $display("test short tune done");
    endtask

    // divide 130, restart by writing the second divider
    task automatic t_tune_long();
        host.write_main(2'h3, 1'b1);
        host.write_two(17'h1abcd);
        chk("select two", 32'h1, rf_output_pin_sel_two);
        chk("two divide", 32'h1abcd, band_two_divide_value);
        timeline(130);
        $display("test long tune done");
    endtask

    task automatic t_select_one();
        host.write_one(18'h25a5a);
        chk("select one", 32'h0, rf_output_pin_sel_two);
        chk("one divide", 32'h25a5a, band_one_divide_value);
        chk("two kept", 32'h1abcd, band_two_divide_value);
        $display("test select one done");
    endtask

    // runs while locked, so only the near limit input can raise the flag
    task automatic t_aux_low();
        near_limit_pin = 1'b1;
        host.write_main(2'h1, 1'b0);
        chk("aux forced", 32'h0, aux_output_pin);
        chk("flag raised", 32'h1, lock_margin_flag_n);
        host.write_main(2'h2, 1'b0);
        chk("aux reserved", 32'h0, aux_output_pin);
        near_limit_pin = 1'b0;
        repeat (6) @(negedge core_clk);
        chk("flag cleared", 32'h0, lock_margin_flag_n);
        $display("test aux low done");
    endtask

    task automatic t_power();
        power_down_pin = 1'b0;
        repeat (6) @(negedge core_clk);
        chk("pin off", 32'h0, {ref_amp_on, rf_circuit_on});
        power_down_pin = 1'b1;
        repeat (6) @(negedge core_clk);
        chk("pin on", 32'h3, {ref_amp_on, rf_circuit_on});
        host.write_power(1'b0);
        chk("bit off", 32'h0, {ref_amp_on, rf_circuit_on});
        $display("test power done");
    endtask

    // reset for 5 cycles, then the scenarios in turn
    initial begin
        nrst = 1'b0;
        power_down_pin = 1'b1;
        reference_input_pin = 1'b0;
        near_limit_pin = 1'b0;
        repeat (5) @(negedge core_clk);
        nrst = 1'b1;
        repeat (4) @(negedge core_clk);
        t_reset();
        t_tune_short();
        t_tune_long();
        t_aux_low();
        t_select_one();
        t_power();
        complete_run();
    end
endmodule // dsc_bank_tb_top
`default_nettype wire
